// [rtl/triac_ctrl_pkg.sv]
// Shared constants and carrier types for the two-channel mains-synchronised
// triac output controller.
// Assumes a 125 MHz system clock and a zero-cross square wave from the mains.
package triac_ctrl_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ        = 125;
  localparam int PHASE_W        = 21;
  localparam int NOM_HALF_US    = 10000;  // 50 Hz half-wave assumed at reset
  localparam int NOM_HALF_CYC   = NOM_HALF_US * CLK_MHZ;
  localparam int ZC_TIMEOUT_US  = 15000;  // No crossing for this long: lost
  localparam int ZC_TIMEOUT_CYC = ZC_TIMEOUT_US * CLK_MHZ;
  localparam int MIN_HALF_US    = 4000;   // Crossing earlier than this: error
  localparam int MIN_HALF_CYC   = MIN_HALF_US * CLK_MHZ;
  localparam logic [2:0] BLANK_EDGES = 3'h6;  // Three mains periods
  localparam logic [3:0] HW_WRAP     = 4'hb;  // Half-wave index runs 0..11

  // ==========================================================================
  // Register offsets
  localparam logic [5:0] OFS_DIG     = 6'h02;
  localparam logic [5:0] OFS_ANG1    = 6'h04;
  localparam logic [5:0] OFS_ANG2    = 6'h06;
  localparam logic [5:0] OFS_PATTERN = 6'h12;
  localparam logic [5:0] OFS_LEAD1   = 6'h14;
  localparam logic [5:0] OFS_LEAD2   = 6'h16;
  localparam logic [5:0] OFS_OUT_CFG = 6'h1c;
  localparam logic [5:0] OFS_TOL     = 6'h1d;
  localparam logic [5:0] OFS_STATUS  = 6'h1e;
  localparam logic [5:0] OFS_FB_MODE = 6'h20;
  localparam logic [5:0] OFS_REQ     = 6'h22;
  localparam logic [5:0] OFS_FB_DIG  = 6'h24;
  localparam logic [5:0] OFS_FB_ANG1 = 6'h26;
  localparam logic [5:0] OFS_FB_ANG2 = 6'h28;

  // ==========================================================================
  // Field positions, limits and reset values
  localparam int CFG_HALF_LSB  = 4;
  localparam int TOL_PLL_BIT   = 7;
  localparam int STAT_ZC_BIT   = 4;
  localparam int STAT_LOST_BIT = 7;
  localparam int REQ_BIT       = 0;
  localparam logic [7:0] OUT_CFG_MASK = 8'h33;
  localparam logic [7:0] OUT_CFG_RST  = 8'h03;
  localparam logic [5:0] LEAD_MIN     = 6'h05;
  localparam logic [5:0] LEAD_MAX     = 6'h32;
  localparam logic [6:0] ANGLE_MAX    = 7'h64;
  localparam logic [4:0] THR_MAX      = 5'h1e;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    MODEL_STD  = 2'b00,
    MODEL_OSP  = 2'b01,
    MODEL_FREQ = 2'b10
  } func_model_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [6:0] angle;
    logic [5:0] lead;
    logic       hw_en;
    logic       blank;
  } chan_cmd_s;

endpackage

// [rtl/triac_fire_timer.sv]
// Firing window of one triac channel within the current half-wave.
// Assumes phase and half-wave length come registered from the controller.
`timescale 1ns/1ps
`default_nettype none
module triac_fire_timer
  import triac_ctrl_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic [PHASE_W-1:0] phase_i,
  input  wire logic [PHASE_W-1:0] half_i,
  input  wire chan_cmd_s          cmd_i,
  output logic                    gate_o
);

  localparam int PROD_W = PHASE_W + 7;

  typedef struct packed {
    logic gate;
  } fire_state_s;

  fire_state_s         s;
  fire_state_s         next_s;
  logic [PROD_W-1:0]   now_scaled;
  logic [PROD_W-1:0]   on_at;
  logic [PROD_W-1:0]   off_at;

  // ==========================================================================
  // Window compare, scaled by 100 so no divider is needed
  always_comb
  begin
    next_s     = s;
    now_scaled = PROD_W'(phase_i) * PROD_W'(ANGLE_MAX);
    on_at      = PROD_W'(half_i) * PROD_W'(ANGLE_MAX - cmd_i.angle);
    off_at     = PROD_W'(half_i) * PROD_W'(ANGLE_MAX - {1'b0, cmd_i.lead});
    next_s.gate = cmd_i.hw_en && !cmd_i.blank && (cmd_i.angle != 7'h00)
                  && (now_scaled >= on_at) && (now_scaled < off_at); // R3 R23
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign gate_o = s.gate;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_lead_off;
    (now_scaled >= off_at) |=> !s.gate;
  endproperty
  a_lead_off: assert property (p_lead_off) // R3
    else $error("gate held inside switch-off lead");

  property p_zero_angle;
    (cmd_i.angle == 7'h00) |=> !s.gate;
  endproperty
  a_zero_angle: assert property (p_zero_angle) // R22
    else $error("gate fired at zero angle");

endmodule
`default_nettype wire

// [rtl/mains_phase_angle_output_ctrl.sv]
// Two-channel mains-synchronised triac controller: register file, zero-cross
// tracking, fault blanking, half-wave patterns and fallback outputs.
// Assumes register writes arrive on the documented register port, and that
// zc_i is a synchronous square wave, high in the positive half-wave.
//
// Behaviour
// (R1) Half-wave pattern register acts only in frequency model.
// (R2) Per-channel 4-bit code selects 100/50/25/33 half-waves, optional delay.
// (R3) Drive ends ahead of zero crossing by a lead of 5..50 percent.
// (R4) Config bits 0/1 pick digital or phase-angle source; default angle.
// (R5) Config bits 4/5 suppress negative half-wave; default full-wave.
// (R6) Half-wave suppression unavailable in frequency model.
// (R7) After threshold of crossing errors, output off three periods, resync.
// (R8) Error threshold is five bits, 0..30, default 0.
// (R9) Bit 7 picks quick or averaging period adjustment.
// (R10) Sync-lost status is 1 while crossings are missing, else 0.
// (R11) Channels start only after master sets the normal request bit; the code holds this in MODEL_OSP only.
// (R12) With request bit set, behave as standard model.
// (R13) Request bit 0: 0 fallback, 1 normal; others read 0; fallback at start.
// (R14) Fallback mode 0 outputs static values, 1 keeps last valid.
// (R15) Static fallback drives digital channels from fallback pattern bits.
// (R16) Static fallback drives analog channels at fallback angle, 0..100.
// (R17) Fallback values apply only if request bit was set before.
// (R18) Communication abort starts fallback output at once.
// (R19) Master keeps its bus cycle at 250 us or longer.
// (R20) Master uses bus cycle of 150 us or more for per-cycle update.
// (R21) Leave fallback only when a transfer delivers a set request bit.
// (R22) Angles are percent; above 100 counts as 100.
// (R23) Firing instants scale with measured half-wave period.
`timescale 1ns/1ps
`default_nettype none
module mains_phase_angle_output_ctrl
  import triac_ctrl_pkg::*;
#(
  parameter int ZC_TIMEOUT_P = ZC_TIMEOUT_CYC,
  parameter int MIN_HALF_P   = MIN_HALF_CYC
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire reg_req_s    reg_req_i,
  input  wire logic        comm_ok_i,
  input  wire func_model_e func_model_i,
  input  wire logic        zc_i,
  output logic [1:0]       gate_o,
  output logic             mains_sync_lost_o,
  output logic             normal_mode_o,
  output logic [15:0]      reg_rdata_o
);

  localparam logic [PHASE_W-1:0] TMO    = PHASE_W'(ZC_TIMEOUT_P);
  localparam logic [PHASE_W-1:0] TMO_M1 = PHASE_W'(ZC_TIMEOUT_P - 1);
  localparam logic [PHASE_W-1:0] MINH   = PHASE_W'(MIN_HALF_P);

  typedef struct packed {
    logic [1:0]         dig;
    logic [1:0][6:0]    ang;
    logic [7:0]         pattern;
    logic [1:0][5:0]    lead;
    logic [7:0]         out_cfg;
    logic [4:0]         tol_thr;
    logic               tol_pll;
    logic               req;
    logic               started;
    logic               fb_mode;
    logic [1:0]         fb_dig;
    logic [1:0][6:0]    fb_ang;
    logic [1:0]         last_dig;
    logic [1:0][6:0]    last_ang;
    logic               zc_q;
    logic [PHASE_W-1:0] phase;
    logic [PHASE_W-1:0] half;
    logic               sync_lost;
    logic [4:0]         err_cnt;
    logic               blanking;
    logic [2:0]         blank_cnt;
    logic [3:0]         hw_cnt;
    logic [1:0]         gate;
    logic               normal;
    logic [15:0]        rdata;
  } ctrl_state_s;

  ctrl_state_s          s;
  ctrl_state_s          next_s;
  chan_cmd_s [1:0]      cmd;
  logic [1:0]           gate_w;
  logic                 zc_edge;
  logic                 err_evt;
  logic                 fallback;
  logic [PHASE_W:0]     pll_sum;
  logic                 sel_dig;
  logic [6:0]           sel_ang;

  // ==========================================================================
  // Helpers
  // Values above 100 percent saturate
  function automatic logic [6:0] clamp_angle(input logic [7:0] v);
    clamp_angle = (v > {1'b0, ANGLE_MAX}) ? ANGLE_MAX : v[6:0]; // R22 R16
  endfunction

  // Out-of-range leads snap to the nearest legal percentage
  function automatic logic [5:0] clamp_lead(input logic [7:0] v);
    if (v < {2'b00, LEAD_MIN})
      clamp_lead = LEAD_MIN;
    else if (v > {2'b00, LEAD_MAX})
      clamp_lead = LEAD_MAX;
    else
      clamp_lead = v[5:0];
  endfunction

  // Half-wave pattern; code bit 3 is ignored, so codes 8..15 act as codes 0..7
  function automatic logic hw_ok(input logic [3:0] code, input logic [3:0] hw);
    logic [1:0] d;
    logic       ok;
    d = code[2] ? ((code[1:0] == 2'b10) ? 2'h2 : 2'h1) : 2'h0;
    case (code[1:0])
      2'b01:   ok = (hw[0] == d[0]);
      2'b10:   ok = (hw[1:0] == d);
      2'b11:   ok = ((hw % 4'h3) == {2'b00, d});
      default: ok = 1'b1;
    endcase
    hw_ok = ok; // R2
  endfunction

  // ==========================================================================
  // Next-state logic
  always_comb
  begin
    next_s   = s;
    cmd      = '0;
    sel_dig  = 1'b0;
    sel_ang  = 7'h00;
    err_evt  = 1'b0;
    zc_edge  = (zc_i != s.zc_q);
    pll_sum  = {1'b0, s.half} + {1'b0, s.phase};
    fallback = (func_model_i == MODEL_OSP) && !s.req; // R12 R13
    next_s.zc_q   = zc_i;
    next_s.normal = !fallback;

    // Phase counter saturates at the dropout limit
    if (s.phase < TMO)
      next_s.phase = s.phase + 1'b1;
    if ((s.phase == TMO_M1) && !s.sync_lost)
    begin
      next_s.sync_lost = 1'b1; // R10
      err_evt          = 1'b1;
    end

    // Crossing: too early is a fault, otherwise restart the half-wave
    if (zc_edge)
    begin
      if (s.phase < MINH)
        err_evt = 1'b1; // R7
      else
      begin
        next_s.phase     = '0;
        next_s.sync_lost = 1'b0; // R10
        // First crossing after dropout only restarts, it measures nothing
        if (!s.sync_lost)
          next_s.half = s.tol_pll ? pll_sum[PHASE_W:1] : s.phase; // R9 R23
        next_s.hw_cnt = (s.hw_cnt == HW_WRAP) ? 4'h0 : s.hw_cnt + 1'b1;
        if (s.blanking)
        begin
          next_s.blank_cnt = s.blank_cnt + 1'b1;
          // Six whole half-waves must pass after the error's partial one,
          // otherwise the dark time falls short of three periods
          if (s.blank_cnt == BLANK_EDGES)
            next_s.blanking = 1'b0; // R7
        end
      end
    end

    // Error threshold reached: blank for three full periods
    if (err_evt)
    begin
      if (s.err_cnt >= s.tol_thr)
      begin
        next_s.blanking  = 1'b1; // R7 R8
        next_s.blank_cnt = 3'h0;
        next_s.err_cnt   = 5'h00;
      end
      else
        next_s.err_cnt = s.err_cnt + 1'b1;
    end

    // Register writes
    if (reg_req_i.wr)
    begin
      case (reg_req_i.addr)
        OFS_DIG:     next_s.dig = reg_req_i.wdata[1:0];
        OFS_ANG1:    next_s.ang[0] = clamp_angle(reg_req_i.wdata[7:0]); // R22
        OFS_ANG2:    next_s.ang[1] = clamp_angle(reg_req_i.wdata[7:0]); // R22
        OFS_PATTERN: next_s.pattern = reg_req_i.wdata[7:0];
        OFS_LEAD1:   next_s.lead[0] = clamp_lead(reg_req_i.wdata[7:0]); // R3
        OFS_LEAD2:   next_s.lead[1] = clamp_lead(reg_req_i.wdata[7:0]); // R3
        OFS_OUT_CFG: next_s.out_cfg = reg_req_i.wdata[7:0] & OUT_CFG_MASK;
        OFS_TOL:
        begin
          next_s.tol_thr = (reg_req_i.wdata[4:0] > THR_MAX) ?
                           THR_MAX : reg_req_i.wdata[4:0]; // R8
          next_s.tol_pll = reg_req_i.wdata[TOL_PLL_BIT]; // R9
        end
        OFS_REQ:
        begin
          next_s.req = reg_req_i.wdata[REQ_BIT]; // R21
          if (reg_req_i.wdata[REQ_BIT])
            next_s.started = 1'b1; // R11 R17
        end
        OFS_FB_MODE: next_s.fb_mode = reg_req_i.wdata[0]; // R14
        OFS_FB_DIG:  next_s.fb_dig = reg_req_i.wdata[1:0]; // R15
        OFS_FB_ANG1: next_s.fb_ang[0] = clamp_angle(reg_req_i.wdata[7:0]); // R16
        OFS_FB_ANG2: next_s.fb_ang[1] = clamp_angle(reg_req_i.wdata[7:0]); // R16
        default:     ;
      endcase
    end

    // Lost link drops the request; a stale write must not re-arm it
    if (!comm_ok_i)
      next_s.req = 1'b0; // R18

    // Register reads, answered one cycle later
    if (reg_req_i.rd)
    begin
      case (reg_req_i.addr)
        OFS_STATUS:
        begin
          next_s.rdata                = 16'h0000;
          next_s.rdata[STAT_ZC_BIT]   = s.zc_q;
          next_s.rdata[STAT_LOST_BIT] = s.sync_lost; // R10
        end
        OFS_REQ:  next_s.rdata = {15'h0000, s.req}; // R13
        default:  next_s.rdata = 16'h0000;
      endcase
    end

    // Per-channel source selection and half-wave gating
    for (int c = 0; c < 2; c++)
    begin
      if (!fallback)
      begin
        next_s.last_dig[c] = s.dig[c]; // R14
        next_s.last_ang[c] = s.ang[c];
        sel_dig = s.dig[c];
        sel_ang = s.ang[c];
      end
      else if (!s.fb_mode)
      begin
        sel_dig = s.fb_dig[c]; // R15
        sel_ang = s.fb_ang[c]; // R16
      end
      else
      begin
        sel_dig = s.last_dig[c]; // R14
        sel_ang = s.last_ang[c];
      end
      // Digital channels fire for the whole window, in step with mains
      cmd[c].angle = s.out_cfg[c] ? sel_ang : (sel_dig ? ANGLE_MAX : 7'h00); // R4
      cmd[c].lead  = s.lead[c];
      if (func_model_i == MODEL_FREQ)
        cmd[c].hw_en = hw_ok(s.pattern[4*c +: 4], s.hw_cnt); // R1 R6
      else
        cmd[c].hw_en = !(s.out_cfg[CFG_HALF_LSB + c] && !s.zc_q); // R5
      // Unsynchronised outputs stay dark, and in fallback model so do never-started ones
      cmd[c].blank = s.blanking || s.sync_lost
                     || ((func_model_i == MODEL_OSP) && !s.started); // R7 R11 R17
    end

    next_s.gate = gate_w;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s           <= '0;
      s.lead      <= {LEAD_MIN, LEAD_MIN}; // R3
      s.out_cfg   <= OUT_CFG_RST; // R4 R5
      s.half      <= PHASE_W'(NOM_HALF_CYC);
      s.sync_lost <= 1'b1;
    end
    else
      s <= next_s;
  end

  // ==========================================================================
  // Channel firing timers
  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    triac_fire_timer u_fire (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .phase_i (s.phase),
      .half_i  (s.half),
      .cmd_i   (cmd[c]),
      .gate_o  (gate_w[c])
    );
  end

  // Outputs straight from the state register
  assign gate_o            = s.gate;
  assign mains_sync_lost_o = s.sync_lost;
  assign normal_mode_o     = s.normal;
  assign reg_rdata_o       = s.rdata;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_timeout;
    (s.phase == TMO_M1) && !s.sync_lost && !zc_edge;
  endsequence

  sequence s_req_rise;
    !s.req ##1 s.req;
  endsequence

  property p_lost_set;
    s_timeout |=> s.sync_lost;
  endproperty
  a_lost_set: assert property (p_lost_set) // R10
    else $error("sync loss not flagged after dropout");

  property p_lost_clr;
    (s.sync_lost && zc_edge && (s.phase >= MINH)) |=> !s.sync_lost;
  endproperty
  a_lost_clr: assert property (p_lost_clr) // R10
    else $error("sync loss not cleared on crossing");

  property p_blank_gate;
    s.blanking |-> ##2 (gate_o == 2'b00);
  endproperty
  a_blank_gate: assert property (p_blank_gate) // R7
    else $error("gate active while blanked");

  property p_osp_start;
    ((func_model_i == MODEL_OSP) && !s.started) |-> ##2 (gate_o == 2'b00);
  endproperty
  a_osp_start: assert property (p_osp_start) // R11
    else $error("gate before normal request");

  property p_abort;
    !comm_ok_i |=> !s.req;
  endproperty
  a_abort: assert property (p_abort) // R18
    else $error("request survives link abort");

  property p_recover;
    s_req_rise |-> $past(reg_req_i.wr && (reg_req_i.addr == OFS_REQ)
                         && reg_req_i.wdata[REQ_BIT]);
  endproperty
  a_recover: assert property (p_recover) // R21
    else $error("left fallback without request transfer");

  property p_thr;
    (reg_req_i.wr && (reg_req_i.addr == OFS_TOL)
     && (reg_req_i.wdata[4:0] == 5'h1f)) |=> (s.tol_thr == THR_MAX);
  endproperty
  a_thr: assert property (p_thr) // R8
    else $error("threshold not capped");

  property p_angle;
    (reg_req_i.wr && (reg_req_i.addr == OFS_ANG1)
     && (reg_req_i.wdata[7:0] > 8'h64)) |=> (s.ang[0] == ANGLE_MAX);
  endproperty
  a_angle: assert property (p_angle) // R22
    else $error("angle not saturated");

  property p_lead;
    (reg_req_i.wr && (reg_req_i.addr == OFS_LEAD1)
     && (reg_req_i.wdata[7:0] < 8'h05)) |=> (s.lead[0] == LEAD_MIN);
  endproperty
  a_lead: assert property (p_lead) // R3
    else $error("lead below minimum accepted");

endmodule
`default_nettype wire

// [sim/mains_master.sv]
// Model of the master controller on the register port, plus the mains
// zero-cross source. Assumes the bench calls its tasks from one process.
`timescale 1ns/1ps
`default_nettype none
module mains_master
  import triac_ctrl_pkg::*;
#(
  parameter int HALF_P = 100,
  parameter int GAP_P  = 4
)
(
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  output var  reg_req_s    req_o,
  output logic             comm_ok_o,
  output logic             zc_o
);
  logic run;
  logic zq;
  logic gl;
  int   cnt;

  // ==========================================================================
  // Mains source: one crossing every HALF_P cycles while running
  initial
  begin
    req_o = '0;
    comm_ok_o = 1'b1;
    run = 1'b0;
    zq = 1'b0;
    gl = 1'b0;
    cnt = 0;
  end
  assign zc_o = zq ^ gl;  // Glitch folds onto the clean square wave
  always @(posedge clk_i)
  begin
    cnt <= (run && cnt < HALF_P - 1) ? cnt + 1 : 0;
    if (run && cnt == HALF_P - 1)
      zq <= ~zq;
  end

  // ==========================================================================
  // Master tasks; each transfer is followed by an idle gap
  task automatic start(input logic v);
    @(posedge clk_i);
    run <= v;
  endtask
  task automatic set_comm(input logic v);
    @(posedge clk_i);
    comm_ok_o <= v;
  endtask
  // Two early crossings inside one half-wave
  task automatic glitch();
    wait (cnt == 20);
    @(posedge clk_i);
    gl <= 1'b1;
    repeat (20) @(posedge clk_i);
    gl <= 1'b0;
  endtask
  task automatic write_reg(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_i);
    req_o.wr <= 1'b1;
    req_o.addr <= a;
    req_o.wdata <= d;
    @(posedge clk_i);
    req_o.wr <= 1'b0;
    req_o.wdata <= ~d;  // Released data no longer shows the old value
    repeat (GAP_P) @(posedge clk_i);
  endtask
  task automatic read_reg(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk_i);
    req_o.rd <= 1'b1;
    req_o.addr <= a;
    @(posedge clk_i);
    req_o.rd <= 1'b0;
    req_o.addr <= ~a;
    @(posedge clk_i);
    d = rdata_i;
    repeat (GAP_P) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the triac output controller.
// Assumes mains_master drives the register port, link state and mains.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import triac_ctrl_pkg::*;
  localparam int HALF  = 100;
  localparam int LIMIT = 60000;
  logic        clk;
  logic        rst_n;
  func_model_e model;
  reg_req_s    req;
  logic        comm_ok;
  logic        zc;
  logic [1:0]  gate;
  logic        sync_lost;
  logic        normal;
  logic [15:0] rdata;
  logic [15:0] rd_d;
  logic [31:0] seed = 32'h0000_cdb0;
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          hi [2];
  int          rs [2];
  int          a;
  int          l;
  int          codes [7] = '{0, 1, 2, 3, 5, 6, 7};
  int          fired [8] = '{12, 6, 3, 4, 12, 6, 3, 4};

  // ==========================================================================
  // Clock, design and partner
  always #4 clk = ~clk;
  mains_phase_angle_output_ctrl #(.ZC_TIMEOUT_P(200), .MIN_HALF_P(50))
    mains_phase_angle_output_ctrl_inst (.clk_i(clk), .rst_n_i(rst_n),
    .reg_req_i(req), .comm_ok_i(comm_ok), .func_model_i(model), .zc_i(zc),
    .gate_o(gate), .mains_sync_lost_o(sync_lost), .normal_mode_o(normal),
    .reg_rdata_o(rdata));
  mains_master #(.HALF_P(HALF)) mm (.clk_i(clk), .rdata_i(rdata),
    .req_o(req), .comm_ok_o(comm_ok), .zc_o(zc));

  // ==========================================================================
  // Reference model: high cycles per half-wave for an angle and a lead
  function automatic int fire(input int ang, input int ld);
    int ac = ang > 100 ? 100 : ang;
    int lc = ld < 5 ? 5 : (ld > 50 ? 50 : ld);
    return ac > lc ? (ac - lc) * HALF / 100 : 0;
  endfunction
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // ==========================================================================
  // Comparison, measurement and closing
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Tolerance covers the one-cycle slack of the measured half period
  task automatic near(input int got, input int exp);
    samples_checked++;
    if (got > exp + 3 || got < exp - 3)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic measure(input int nh);
    logic [1:0] prv;
    @(zc);
    prv = gate;
    hi = '{0, 0};
    rs = '{0, 0};
    repeat (nh * HALF)
    begin
      @(posedge clk);
      for (int c = 0; c < 2; c++)
      begin
        hi[c] += (gate[c] === 1'b1);
        rs[c] += (gate[c] === 1'b1 && prv[c] !== 1'b1);
      end
      prv = gate;
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fails++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    clk   = 1'b0;
    rst_n = 1'b0;
    model = MODEL_STD;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, looked at settled before the first edge after release
    @(negedge clk);
    check({gate, sync_lost, normal}, 16'h0002);
    mm.read_reg(OFS_STATUS, rd_d);
    check(rd_d & 16'h0080, 16'h0080);
    mm.read_reg(OFS_REQ, rd_d);
    check(rd_d, 16'h0000);
    mm.start(1'b1);
    repeat (14 * HALF) @(posedge clk);
    check(sync_lost, 1'b0);
    mm.read_reg(OFS_STATUS, rd_d);
    check({rd_d[7], rd_d[4]}, {1'b0, zc});
    // Angle and lead, clamped corners first, then random values
    for (int i = 0; i < 6; i++)
    begin
      a = i < 2 ? (i == 0 ? 100 : 150) : int'(rnd() % 101);
      l = i < 2 ? (i == 0 ? 2 : 60) : 5 + int'(rnd() % 46);
      mm.write_reg(OFS_ANG1, 16'(a));
      mm.write_reg(OFS_ANG2, 16'(a / 2));
      mm.write_reg(OFS_LEAD1, 16'(l));
      mm.write_reg(OFS_LEAD2, 16'(l));
      measure(2);
      near(hi[0], 2 * fire(a, l));
      near(hi[1], 2 * fire(a / 2, l));
    end
    mm.write_reg(OFS_LEAD1, 16'h000a);
    mm.write_reg(OFS_LEAD2, 16'h000a);
    mm.write_reg(OFS_OUT_CFG, 16'h0000);
    mm.write_reg(OFS_DIG, 16'h0001);
    measure(2);
    near(hi[0], 2 * fire(100, 10));
    near(hi[1], 0);
    mm.write_reg(OFS_OUT_CFG, 16'h0013);
    mm.write_reg(OFS_ANG1, 16'h003c);
    mm.write_reg(OFS_ANG2, 16'h003c);
    measure(2);
    near(hi[0], fire(60, 10));
    near(hi[1], 2 * fire(60, 10));
    mm.write_reg(OFS_PATTERN, 16'h0022);
    measure(12);
    check(16'(rs[0]), 16'd6);
    @(posedge clk);
    model <= MODEL_FREQ;
    for (int i = 0; i < 7; i++)
    begin
      mm.write_reg(OFS_PATTERN, 16'(codes[i] | (codes[6 - i] << 4)));
      measure(1);
      measure(12);
      check(16'(rs[0]), 16'(fired[codes[i]]));
      check(16'(rs[1]), 16'(fired[codes[6 - i]]));
    end
    // Fallback model: nothing fires before the first normal request
    @(posedge clk);
    model <= MODEL_OSP;
    mm.write_reg(OFS_OUT_CFG, 16'h0002);
    mm.write_reg(OFS_DIG, 16'h0000);
    measure(2);
    check({gate, normal}, 3'h0);
    near(hi[1], 0);
    mm.write_reg(OFS_REQ, 16'h00ff);
    check(normal, 1'b1);
    mm.read_reg(OFS_REQ, rd_d);
    check(rd_d, 16'h0001);
    measure(2);
    near(hi[1], 2 * fire(60, 10));
    mm.write_reg(OFS_FB_MODE, 16'h0000);
    mm.write_reg(OFS_FB_DIG, 16'h0001);
    mm.write_reg(OFS_FB_ANG2, 16'h001e);
    mm.set_comm(1'b0);
    repeat (3) @(posedge clk);
    check(normal, 1'b0);
    measure(2);
    near(hi[0], 2 * fire(100, 10));
    near(hi[1], 2 * fire(30, 10));
    mm.set_comm(1'b1);
    mm.read_reg(OFS_REQ, rd_d);
    check({rd_d, normal}, 17'h0_0000);
    mm.write_reg(OFS_REQ, 16'h0001);
    mm.write_reg(OFS_FB_MODE, 16'h0001);
    mm.set_comm(1'b0);
    measure(2);
    near(hi[0], 0);
    near(hi[1], 2 * fire(60, 10));
    // Crossing errors blank the output for three mains periods
    mm.set_comm(1'b1);
    mm.write_reg(OFS_REQ, 16'h0001);
    mm.write_reg(OFS_OUT_CFG, 16'h0003);
    mm.write_reg(OFS_TOL, 16'h009f);
    mm.write_reg(OFS_TOL, 16'h0080);
    mm.glitch();
    measure(5);
    check(16'(rs[0] + rs[1]), 16'h0000);
    measure(1);
    check(16'(rs[0] + rs[1]), 16'h0000);
    measure(4);
    check(16'(rs[0] + rs[1]), 16'h0008);
    // Mains dropout
    mm.start(1'b0);
    repeat (250) @(posedge clk);
    check({gate, sync_lost}, 3'h1);
    report_and_stop();
  end
endmodule
`default_nettype wire
